// file: include/rmc_pkg.sv
// shared constants and types for the real mode control unit
package rmc_pkg;
	// ==========================================================
	// operating control word
	localparam int CW_W = 16;
	localparam logic [15:0] CW_RESET = 16'hfff0;
	localparam logic [11:0] CW_UPPER_ONES = 12'hfff;
	localparam int PE_BIT = 0;
	localparam int MP_BIT = 1;
	localparam int EM_BIT = 2;
	localparam int TS_BIT = 3;
	// ==========================================================
	// vector table
	localparam int VT_BASE_W = 24;
	localparam int VT_LIMIT_W = 16;
	localparam logic [23:0] VT_BASE_RESET = 24'h000000;
	localparam logic [15:0] VT_LIMIT_RESET = 16'h03ff;
	localparam logic [1:0] VT_ENTRY_LAST = 2'h3;
	localparam logic [5:0] VT_PAD = 6'h00;
	// ==========================================================
	// exception vectors
	localparam logic [7:0] VEC_COPROC_NA = 8'h07;
	localparam logic [7:0] VEC_TABLE_LIMIT = 8'h08;
	localparam logic [7:0] VEC_COPROC_OVERRUN = 8'h09;
	localparam logic [7:0] VEC_SEG_OVERRUN = 8'h0d;
	// ==========================================================
	// addressing
	localparam int ADDR_W = 20;
	localparam logic [3:0] SEG_LOW_ZERO = 4'h0;
	localparam logic [15:0] OFFSET_LAST = 16'hffff;
	localparam logic [16:0] OFFSET_SPAN = 17'h10000;
	localparam logic [15:0] SP_WRAP_ODD = 16'h0001;
	localparam logic [19:0] START_ADDR = 20'hffff0;
	// ==========================================================
	// shutdown release thresholds
	localparam logic [15:0] SHUT_MIN_LIMIT = 16'h000f;
	localparam logic [15:0] SHUT_MIN_SP = 16'h0005;
	typedef enum logic [1:0] {RMC_RUN, RMC_HALT, RMC_SHUT} rmc_state_t;
endpackage

// file: include/rmc_core_if.sv
// carrier between the control unit, fault classifier and address former
`timescale 1ns/1ps
interface rmc_core_if;
	import rmc_pkg::*;
	logic mp, em, ts;
	logic [15:0] limit;
	logic is_esc, is_sync, is_soft_int, is_stack_push, fetch_wrap;
	logic [7:0] soft_vec;
	logic mem_access, mem_word;
	logic [15:0] offset, selector, sp;
	logic [3:0] mem_len;
	logic fault_hit, ret_before, to_shut;
	logic [7:0] fault_vec;
	logic [19:0] phys;
	logic carry, bhe_n;
	modport top_mp(output mp, em, ts, limit, is_esc, is_sync, is_soft_int, is_stack_push, fetch_wrap,
		soft_vec, mem_access, mem_word, offset, selector, sp, mem_len,
		input fault_hit, ret_before, to_shut, fault_vec, phys, carry, bhe_n);
	modport fault_mp(input mp, em, ts, limit, is_esc, is_sync, is_soft_int, is_stack_push, fetch_wrap,
		soft_vec, mem_access, mem_word, offset, sp, mem_len, output fault_hit, ret_before, to_shut, fault_vec);
	modport addr_mp(input selector, offset, mem_word, output phys, carry, bhe_n);
endinterface

// file: hw/rmc_fault.sv
// classifies one instruction into the real mode addressing and coprocessor exceptions
`timescale 1ns/1ps
module rmc_fault (
	rmc_core_if.fault_mp bus
);
	import rmc_pkg::*;
	// ==========================================================
	// vector table reach
	function automatic logic in_table(input logic [7:0] vec, input logic [15:0] lim);
		in_table = ({VT_PAD, vec, VT_ENTRY_LAST} <= lim);
	endfunction
	wire esc_trap = bus.is_esc & (bus.em | bus.ts); //RULE_05
	wire cp_trap = esc_trap | (bus.is_sync & bus.mp & bus.ts); //RULE_03
	wire [16:0] esc_end = {1'b0, bus.offset} + {13'h0000, bus.mem_len}; //RULE_15
	wire esc_over = bus.is_esc & bus.mem_access & (esc_end > OFFSET_SPAN); //RULE_10
	wire seg_over = (bus.mem_access & bus.mem_word & (bus.offset == OFFSET_LAST)) | bus.fetch_wrap; //RULE_11
	wire lim_trap = bus.is_soft_int & ~in_table(bus.soft_vec, bus.limit); //RULE_09
	// odd stack pointer at one means the word push straddles the segment end
	wire stack_wrap = bus.is_stack_push & (bus.sp == SP_WRAP_ODD); //RULE_21
	wire [7:0] vec_sel = cp_trap ? VEC_COPROC_NA :
		seg_over ? VEC_SEG_OVERRUN :
		esc_over ? VEC_COPROC_OVERRUN : VEC_TABLE_LIMIT;
	wire needs_table = (vec_sel == VEC_TABLE_LIMIT) | (vec_sel == VEC_SEG_OVERRUN);
	assign bus.fault_hit = cp_trap | seg_over | esc_over | lim_trap | stack_wrap;
	assign bus.fault_vec = vec_sel;
	assign bus.ret_before = (vec_sel != VEC_COPROC_OVERRUN); //RULE_10
	assign bus.to_shut = stack_wrap | (needs_table & ~in_table(vec_sel, bus.limit)); //RULE_21
endmodule

// file: hw/rmc_addr.sv
// real mode physical address former
`timescale 1ns/1ps
module rmc_addr #(
	parameter int PHYS_W = 20
) (
	rmc_core_if.addr_mp bus
);
	import rmc_pkg::*;
	if (PHYS_W != ADDR_W) begin : g_check
		$error("rmc_addr serves only a 20 bit real mode address");
	end
	// ==========================================================
	// base on a 16 byte boundary plus offset; the carry is left for the upper lines
	wire [20:0] sum = {1'b0, bus.selector, SEG_LOW_ZERO} + {5'h00, bus.offset}; //RULE_14
	assign bus.phys = sum[19:0]; //RULE_12
	assign bus.carry = sum[20];
	assign bus.bhe_n = ~(bus.mem_word | sum[0]);
endmodule

// file: hw/rmc_top.sv
// real mode control word, halt, shutdown and addressing exception unit
//
// Contract
// RULE_01: reset loads control word with upper twelve bits set, low four clear.
// RULE_02: protection enable bit sets protected mode and clears only by reset.
// RULE_03: monitor bit lets synchronisation instructions raise exception 7.
// RULE_04: emulate bit makes every escape instruction raise exception 7.
// RULE_05: task switched bit makes the next coprocessor instruction raise exception 7.
// RULE_06: software should set monitor and task switched bits with stale coprocessor context.
// RULE_07: halt stops execution and bus; only nmi, enabled maskable request or reset wake.
// RULE_08: interrupt leaving halt returns to the instruction after the stop.
// RULE_09: software interrupt beyond table limit raises exception 8, return at fault.
// RULE_10: escape operand past offset ffff raises interrupt 9, return not at fault.
// RULE_11: word at offset ffff or fetch past segment end raises exception 13.
// RULE_12: real mode addresses one megabyte on twenty lines and byte high enable.
// RULE_13: system ignores the four upper address lines in real mode.
// RULE_14: segment base is selector shifted left by four bits.
// RULE_15: segments are 64K, readable, writable, executable; wrapping may trap.
// RULE_16: first fetch after reset is from physical address ffff0.
// RULE_17: system reserves addresses 00000 to 003ff for the vector table.
// RULE_18: addressing exceptions restore prior state except stack push and pop forms.
// RULE_19: vector table holds 24 bit base, 16 bit limit; reset zero and 03ff.
// RULE_20: halt and shutdown use a halt cycle; address bit 1 high means halt.
// RULE_21: shutdown on exception 8 or 13 outside limit, or odd stack wrap.
// RULE_22: nmi leaves shutdown only with limit at least 000f and sp above 0005.
`timescale 1ns/1ps
module rmc_top (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic nmi_pin,
	input wire logic maskable_request,
	input wire logic maskable_request_enable,
	input wire logic ctl_load,
	input wire logic [rmc_pkg::CW_W-1:0] ctl_wdata,
	input wire logic vt_load,
	input wire logic [rmc_pkg::VT_BASE_W-1:0] vt_base_wdata,
	input wire logic [rmc_pkg::VT_LIMIT_W-1:0] vt_limit_wdata,
	input wire logic instr_valid,
	input wire logic instr_escape,
	input wire logic instr_sync,
	input wire logic instr_stop,
	input wire logic instr_soft_int,
	input wire logic [7:0] soft_int_vector,
	input wire logic instr_stack,
	input wire logic instr_stack_push,
	input wire logic fetch_wrap,
	input wire logic mem_access,
	input wire logic mem_word,
	input wire logic [15:0] mem_offset,
	input wire logic [3:0] mem_len,
	input wire logic [15:0] seg_selector,
	input wire logic [15:0] instr_ip,
	input wire logic [15:0] next_ip,
	input wire logic [15:0] stack_pointer,
	output logic [rmc_pkg::CW_W-1:0] operating_control_word,
	output logic protection_enable_bit,
	output logic [rmc_pkg::VT_BASE_W-1:0] vector_table_base,
	output logic [rmc_pkg::VT_LIMIT_W-1:0] vector_table_limit,
	output logic exc_valid,
	output logic [7:0] exc_vector,
	output logic [15:0] return_ip,
	output logic exc_restore,
	output logic wake_valid,
	output logic halted,
	output logic shutdown,
	output logic bus_idle,
	output logic halt_cycle,
	output logic halt_a1,
	output logic start_fetch,
	output logic [rmc_pkg::ADDR_W-1:0] phys_addr,
	output logic [3:0] upper_addr,
	output logic byte_high_enable_n
);
	import rmc_pkg::*;

	// ==========================================================
	// pin synchronisers
	logic nmi_meta_ff, nmi_sync_ff, nmi_prev_ff;
	logic mreq_meta_ff, mreq_sync_ff;
	always_ff @(posedge core_clk) begin
		nmi_meta_ff <= nmi_pin;
		nmi_sync_ff <= nmi_meta_ff;
		mreq_meta_ff <= maskable_request;
		mreq_sync_ff <= mreq_meta_ff;
	end
	always_ff @(posedge core_clk) begin
		if (reset) begin
			nmi_prev_ff <= 1'b0;
		end else begin
			nmi_prev_ff <= nmi_sync_ff;
		end
	end
	// nmi is edge triggered; the maskable request is a level
	wire nmi_rise = nmi_sync_ff & ~nmi_prev_ff;

	// ==========================================================
	// registers
	rmc_state_t state_ff, nxt_state;
	logic [15:0] ctl_word_ff, nxt_ctl_word;
	logic [23:0] vt_base_ff, nxt_vt_base;
	logic [15:0] vt_limit_ff, nxt_vt_limit;
	logic [15:0] halt_ip_ff, nxt_halt_ip;
	logic exc_valid_ff, nxt_exc_valid;
	logic [7:0] exc_vector_ff, nxt_exc_vector;
	logic [15:0] return_ip_ff, nxt_return_ip;
	logic exc_restore_ff, nxt_exc_restore;
	logic wake_valid_ff, nxt_wake_valid;
	logic halt_cycle_ff, nxt_halt_cycle;
	logic halt_a1_ff, nxt_halt_a1;
	logic halted_ff, shutdown_ff, bus_idle_ff;
	logic start_pend_ff, start_fetch_ff;
	logic [19:0] phys_ff, nxt_phys;
	logic [3:0] upper_ff;
	logic bhe_n_ff;

	// ==========================================================
	// helpers
	rmc_core_if core ();
	assign core.mp = ctl_word_ff[MP_BIT];
	assign core.em = ctl_word_ff[EM_BIT];
	assign core.ts = ctl_word_ff[TS_BIT];
	assign core.limit = vt_limit_ff;
	assign core.is_esc = instr_escape;
	assign core.is_sync = instr_sync;
	assign core.is_soft_int = instr_soft_int;
	assign core.is_stack_push = instr_stack_push;
	assign core.fetch_wrap = fetch_wrap;
	assign core.soft_vec = soft_int_vector;
	assign core.mem_access = mem_access;
	assign core.mem_word = mem_word;
	assign core.offset = mem_offset;
	assign core.selector = seg_selector;
	assign core.sp = stack_pointer;
	assign core.mem_len = mem_len;

	rmc_fault u_fault (
		.bus(core.fault_mp)
	);
	rmc_addr #(
		.PHYS_W(ADDR_W)
	) u_addr (
		.bus(core.addr_mp)
	);

	// ==========================================================
	// decode
	wire running = (state_ff == RMC_RUN);
	wire take = running & instr_valid & ~start_pend_ff;
	wire take_fault = take & core.fault_hit;
	wire take_shut = take_fault & core.to_shut;
	wire take_stop = take & ~core.fault_hit & instr_stop;
	wire halt_wake = (state_ff == RMC_HALT) & (nmi_rise | (mreq_sync_ff & maskable_request_enable)); //RULE_07
	wire shut_ok = (vt_limit_ff >= SHUT_MIN_LIMIT) & (stack_pointer > SHUT_MIN_SP);
	wire shut_wake = (state_ff == RMC_SHUT) & nmi_rise & shut_ok; //RULE_22
	// only the low four bits load; protection enable is or-ed in so it can never drop
	wire [15:0] ctl_loaded = {CW_UPPER_ONES, ctl_wdata[TS_BIT:MP_BIT], ctl_wdata[PE_BIT] | ctl_word_ff[PE_BIT]};

	// ==========================================================
	// next state
	always_comb begin
		nxt_state = state_ff;
		nxt_halt_ip = halt_ip_ff;
		nxt_exc_valid = 1'b0;
		nxt_exc_vector = exc_vector_ff;
		nxt_return_ip = return_ip_ff;
		nxt_exc_restore = exc_restore_ff;
		nxt_wake_valid = 1'b0;
		nxt_halt_cycle = 1'b0;
		nxt_halt_a1 = halt_a1_ff;
		case (state_ff)
			RMC_RUN: begin
				if (take_shut) begin
					nxt_state = RMC_SHUT; //RULE_21
					nxt_halt_cycle = 1'b1;
					nxt_halt_a1 = 1'b0; //RULE_20
				end else if (take_fault) begin
					nxt_exc_valid = 1'b1; //RULE_04
					nxt_exc_vector = core.fault_vec;
					nxt_return_ip = core.ret_before ? instr_ip : next_ip; //RULE_09
					// stack forms may already have moved the pointer
					nxt_exc_restore = core.ret_before & ~instr_stack; //RULE_18
				end else if (take_stop) begin
					nxt_state = RMC_HALT;
					nxt_halt_ip = next_ip;
					nxt_halt_cycle = 1'b1;
					nxt_halt_a1 = 1'b1; //RULE_20
				end
			end
			RMC_HALT: begin
				if (halt_wake) begin
					nxt_state = RMC_RUN;
					nxt_wake_valid = 1'b1;
					nxt_return_ip = halt_ip_ff; //RULE_08
				end
			end
			RMC_SHUT: begin
				if (shut_wake) begin
					nxt_state = RMC_RUN;
					nxt_wake_valid = 1'b1;
					nxt_return_ip = halt_ip_ff;
				end
			end
			default: begin
				nxt_state = RMC_RUN;
			end
		endcase
	end

	always_comb begin
		nxt_ctl_word = ctl_word_ff;
		if (ctl_load & running) begin
			nxt_ctl_word = ctl_loaded; //RULE_02
		end
	end

	always_comb begin
		nxt_vt_base = vt_base_ff;
		nxt_vt_limit = vt_limit_ff;
		if (vt_load & running) begin
			nxt_vt_base = vt_base_wdata; //RULE_19
			nxt_vt_limit = vt_limit_wdata;
		end
	end

	// the start address wins the address lines for the first cycle out of reset
	assign nxt_phys = start_pend_ff ? START_ADDR : core.phys; //RULE_16

	// ==========================================================
	// flops
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_ff <= RMC_RUN;
			ctl_word_ff <= CW_RESET; //RULE_01
			vt_base_ff <= VT_BASE_RESET; //RULE_19
			vt_limit_ff <= VT_LIMIT_RESET;
			halt_ip_ff <= 16'h0000;
		end else begin
			state_ff <= nxt_state;
			ctl_word_ff <= nxt_ctl_word;
			vt_base_ff <= nxt_vt_base;
			vt_limit_ff <= nxt_vt_limit;
			halt_ip_ff <= nxt_halt_ip;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			exc_valid_ff <= 1'b0;
			exc_vector_ff <= 8'h00;
			return_ip_ff <= 16'h0000;
			exc_restore_ff <= 1'b0;
			wake_valid_ff <= 1'b0;
		end else begin
			exc_valid_ff <= nxt_exc_valid;
			exc_vector_ff <= nxt_exc_vector;
			return_ip_ff <= nxt_return_ip;
			exc_restore_ff <= nxt_exc_restore;
			wake_valid_ff <= nxt_wake_valid;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			halt_cycle_ff <= 1'b0;
			halt_a1_ff <= 1'b0;
			halted_ff <= 1'b0;
			shutdown_ff <= 1'b0;
			bus_idle_ff <= 1'b1;
		end else begin
			halt_cycle_ff <= nxt_halt_cycle;
			halt_a1_ff <= nxt_halt_a1;
			halted_ff <= (nxt_state == RMC_HALT);
			shutdown_ff <= (nxt_state == RMC_SHUT);
			bus_idle_ff <= (nxt_state != RMC_RUN); //RULE_07
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			start_pend_ff <= 1'b1;
			start_fetch_ff <= 1'b0;
			phys_ff <= START_ADDR;
			upper_ff <= 4'h0;
			bhe_n_ff <= 1'b1;
		end else begin
			start_pend_ff <= 1'b0;
			start_fetch_ff <= start_pend_ff; //RULE_16
			phys_ff <= nxt_phys; //RULE_12
			// only the carry reaches the upper lines, so they can read nonzero
			upper_ff <= {3'h0, core.carry & ~start_pend_ff}; //RULE_13
			bhe_n_ff <= start_pend_ff | core.bhe_n;
		end
	end

	// ==========================================================
	// outputs
	assign operating_control_word = ctl_word_ff;
	assign protection_enable_bit = ctl_word_ff[PE_BIT];
	assign vector_table_base = vt_base_ff;
	assign vector_table_limit = vt_limit_ff;
	assign exc_valid = exc_valid_ff;
	assign exc_vector = exc_vector_ff;
	assign return_ip = return_ip_ff;
	assign exc_restore = exc_restore_ff;
	assign wake_valid = wake_valid_ff;
	assign halted = halted_ff;
	assign shutdown = shutdown_ff;
	assign bus_idle = bus_idle_ff;
	assign halt_cycle = halt_cycle_ff;
	assign halt_a1 = halt_a1_ff;
	assign start_fetch = start_fetch_ff;
	assign phys_addr = phys_ff;
	assign upper_addr = upper_ff;
	assign byte_high_enable_n = bhe_n_ff;

	// ==========================================================
	// checks
	AST_CW_RESET: assert property (@(posedge core_clk) reset |=> ctl_word_ff == CW_RESET) //RULE_01
		else $error("control word not fff0 after reset");
	AST_PE_STICKY: assert property (@(posedge core_clk) disable iff (reset) //RULE_02
		ctl_word_ff[PE_BIT] |=> ctl_word_ff[PE_BIT])
		else $error("protection enable dropped without reset");
	AST_SYNC_TRAP: assert property (@(posedge core_clk) disable iff (reset) //RULE_03
		(take & instr_sync & ~instr_escape & ctl_word_ff[MP_BIT] & ctl_word_ff[TS_BIT])
		|=> exc_valid_ff && exc_vector_ff == 8'h07)
		else $error("monitored sync did not trap to 7");
	AST_EMU_TRAP: assert property (@(posedge core_clk) disable iff (reset) //RULE_04
		(take & instr_escape & ctl_word_ff[EM_BIT]) |=> exc_valid_ff && exc_vector_ff == 8'h07)
		else $error("escape under emulation did not trap to 7");
	AST_TS_TRAP: assert property (@(posedge core_clk) disable iff (reset) //RULE_05
		(take & instr_escape & ctl_word_ff[TS_BIT]) |=> exc_valid_ff && exc_vector_ff == 8'h07)
		else $error("escape after task switch did not trap");
	AST_HALT_QUIET: assert property (@(posedge core_clk) disable iff (reset) //RULE_07
		(state_ff == RMC_HALT && !halt_wake) |=> bus_idle_ff && !exc_valid_ff && state_ff == RMC_HALT)
		else $error("halt left or bus used without wake");
	AST_WAKE_IP: assert property (@(posedge core_clk) disable iff (reset) //RULE_08
		halt_wake |=> wake_valid_ff && return_ip_ff == $past(halt_ip_ff))
		else $error("halt wake return address wrong");
	AST_LIMIT_TRAP: assert property (@(posedge core_clk) disable iff (reset) //RULE_09
		(take & instr_soft_int & ~core.to_shut & ~core.fault_vec[0] & ({soft_int_vector, 2'h3} > {2'h0, vt_limit_ff}))
		|=> exc_valid_ff && return_ip_ff == $past(instr_ip))
		else $error("vector beyond limit did not fault at instruction");
	AST_SEG_TRAP: assert property (@(posedge core_clk) disable iff (reset) //RULE_11
		(take & mem_access & mem_word & mem_offset == 16'hffff & ~core.to_shut & ~core.fault_vec[1])
		|=> exc_valid_ff && exc_vector_ff == 8'h0d)
		else $error("word at ffff did not raise 13");
	AST_HALT_A1: assert property (@(posedge core_clk) disable iff (reset) //RULE_20
		halt_cycle_ff |-> (halt_a1_ff == halted_ff) && (halted_ff != shutdown_ff))
		else $error("halt cycle address bit 1 wrong");
	AST_SHUT_HOLD: assert property (@(posedge core_clk) disable iff (reset) //RULE_22
		(state_ff == RMC_SHUT && !(nmi_rise && vt_limit_ff >= 16'h000f && stack_pointer > 16'h0005))
		|=> state_ff == RMC_SHUT)
		else $error("shutdown left without qualified nmi");
	AST_START: assert property (@(posedge core_clk) $fell(reset) |=> start_fetch_ff && phys_ff == 20'hffff0) //RULE_16
		else $error("first fetch not at ffff0");
endmodule

// file: test/rmc_sys_model.sv
// system bus logic model: decodes halt cycles and the reserved vector area
`timescale 1ns/1ps
module rmc_sys_model (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic halt_cycle,
	input wire logic halt_a1,
	input wire logic [19:0] phys_addr,
	input wire logic [3:0] upper_addr,
	output logic [7:0] halt_count,
	output logic [7:0] shut_count,
	output logic vec_area
);
	// ==========================================================
	// decode
	// upper lines may be nonzero in real mode, so nothing here looks at them
	wire logic [3:0] upper_ignored = upper_addr;
	assign vec_area = (phys_addr <= 20'h003ff);
	always_ff @(posedge core_clk) begin
		if (reset) begin
			halt_count <= 8'h00;
			shut_count <= 8'h00;
		end else if (halt_cycle && halt_a1) begin
			halt_count <= halt_count + 8'h01;
		end else if (halt_cycle) begin
			shut_count <= shut_count + 8'h01;
		end
	end
endmodule

// file: test/rmc_top_bench.sv
// self-checking bench for the real mode control unit
`timescale 1ns/1ps
module rmc_top_bench;
	import rmc_pkg::*;
	logic core_clk, reset, nmi_pin, maskable_request, maskable_request_enable, ctl_load, vt_load, instr_valid;
	logic instr_escape, instr_sync, instr_stop, instr_soft_int, instr_stack, instr_stack_push;
	logic fetch_wrap, mem_access, mem_word;
	logic [15:0] ctl_wdata, vt_limit_wdata, mem_offset, seg_selector, instr_ip, next_ip, stack_pointer;
	logic [23:0] vt_base_wdata, vector_table_base;
	logic [7:0] soft_int_vector, exc_vector, halt_count, shut_count;
	logic [3:0] mem_len, upper_addr;
	logic [15:0] operating_control_word, vector_table_limit, return_ip;
	logic protection_enable_bit, exc_valid, exc_restore, wake_valid, halted, shutdown, bus_idle;
	logic halt_cycle, halt_a1, start_fetch, byte_high_enable_n, vec_area, got;
	logic [19:0] phys_addr;
	int mismatches = 0;
	int checks_done = 0;
	rmc_top DUT (.core_clk, .reset, .nmi_pin, .maskable_request, .maskable_request_enable, .ctl_load, .ctl_wdata,
		.vt_load, .vt_base_wdata, .vt_limit_wdata, .instr_valid, .instr_escape, .instr_sync, .instr_stop,
		.instr_soft_int, .soft_int_vector, .instr_stack, .instr_stack_push, .fetch_wrap, .mem_access,
		.mem_word, .mem_offset, .mem_len, .seg_selector, .instr_ip, .next_ip, .stack_pointer,
		.operating_control_word, .protection_enable_bit, .vector_table_base, .vector_table_limit,
		.exc_valid, .exc_vector, .return_ip, .exc_restore, .wake_valid, .halted, .shutdown, .bus_idle,
		.halt_cycle, .halt_a1, .start_fetch, .phys_addr, .upper_addr, .byte_high_enable_n);
	rmc_sys_model sys (.core_clk, .reset, .halt_cycle, .halt_a1, .phys_addr, .upper_addr,
		.halt_count, .shut_count, .vec_area);
	// ==========================================================
	// tasks
	always #2.5 core_clk = ~core_clk;
	task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick;
		@(posedge core_clk);
		#1;
	endtask
	task automatic ctl(input logic [15:0] d);
		ctl_wdata = d;
		ctl_load = 1'b1;
		tick();
		ctl_load = 1'b0;
	endtask
	task automatic vt(input logic [23:0] b, input logic [15:0] l);
		vt_base_wdata = b;
		vt_limit_wdata = l;
		vt_load = 1'b1;
		tick();
		vt_load = 1'b0;
	endtask
	// one instruction; class flags are set by the caller and cleared here
	task automatic go;
		instr_valid = 1'b1;
		tick();
		{instr_valid, instr_escape, instr_sync, instr_stop, instr_soft_int} = 5'h00;
		{instr_stack, instr_stack_push, fetch_wrap, mem_access, mem_word} = 5'h00;
	endtask
	task automatic exc(input logic [7:0] v, input logic [15:0] ip, input logic r);
		chk("exc_valid", exc_valid, 1'b1);
		chk("exc_vector", exc_vector, v);
		chk("return_ip", return_ip, ip);
		chk("exc_restore", exc_restore, r);
	endtask
	// synchronisers delay the pins, so the wake is polled under a bound
	task automatic wait_wake;
		got = 1'b0;
		repeat (8) begin
			tick();
			if (wake_valid === 1'b1) got = 1'b1;
		end
	endtask
	task automatic end_test(input string nm);
		$display("test %s finished", nm);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#20000;
		mismatches++;
		report_and_stop();
	end
	// ==========================================================
	// tests
	initial begin
		core_clk = 1'b0;
		reset = 1'b1;
		{nmi_pin, maskable_request, maskable_request_enable, ctl_load, vt_load, instr_valid} = 6'h00;
		{instr_escape, instr_sync, instr_stop, instr_soft_int, instr_stack, instr_stack_push} = 6'h00;
		{fetch_wrap, mem_access, mem_word} = 3'h0;
		{ctl_wdata, vt_limit_wdata, mem_offset, seg_selector} = 64'h0;
		vt_base_wdata = 24'h000000;
		soft_int_vector = 8'h00;
		mem_len = 4'h1;
		instr_ip = 16'h0100;
		next_ip = 16'h0103;
		stack_pointer = 16'h0100;
		repeat (8) tick();
		chk("control_word", operating_control_word, 16'hfff0);
		chk("vt_base", vector_table_base, 24'h000000);
		chk("vt_limit", vector_table_limit, 16'h03ff);
		reset = 1'b0;
		tick();
		chk("start_fetch", start_fetch, 1'b1);
		chk("phys_addr", phys_addr, 20'hffff0);
		end_test("reset");
		seg_selector = 16'h1234;
		mem_offset = 16'h0010;
		tick();
		tick();
		chk("phys_addr", phys_addr, 20'h12350);
		chk("bhe_n", byte_high_enable_n, 1'b1);
		chk("vec_area", vec_area, 1'b0);
		seg_selector = 16'hffff;
		mem_offset = 16'h0011;
		mem_word = 1'b1;
		tick();
		mem_word = 1'b0;
		chk("phys_addr", phys_addr, 20'h00001);
		chk("upper_addr", upper_addr, 4'h1);
		chk("bhe_n", byte_high_enable_n, 1'b0);
		chk("vec_area", vec_area, 1'b1);
		end_test("address");
		ctl(16'h0004);
		chk("control_word", operating_control_word, 16'hfff4);
		instr_escape = 1'b1;
		go();
		exc(VEC_COPROC_NA, 16'h0100, 1'b1);
		ctl(16'h0008);
		instr_escape = 1'b1;
		go();
		exc(VEC_COPROC_NA, 16'h0100, 1'b1);
		ctl(16'h000a);
		instr_sync = 1'b1;
		go();
		exc(VEC_COPROC_NA, 16'h0100, 1'b1);
		ctl(16'h0002);
		instr_sync = 1'b1;
		go();
		chk("exc_valid", exc_valid, 1'b0);
		ctl(16'h0000);
		instr_escape = 1'b1;
		go();
		chk("exc_valid", exc_valid, 1'b0);
		end_test("coprocessor");
		vt(24'h012345, 16'h007f);
		chk("vt_base", vector_table_base, 24'h012345);
		chk("vt_limit", vector_table_limit, 16'h007f);
		instr_soft_int = 1'b1;
		soft_int_vector = 8'h20;
		go();
		exc(VEC_TABLE_LIMIT, 16'h0100, 1'b1);
		instr_soft_int = 1'b1;
		soft_int_vector = 8'h1f;
		go();
		chk("exc_valid", exc_valid, 1'b0);
		{instr_escape, mem_access, mem_offset, mem_len} = {2'h3, 16'hfffe, 4'h4};
		go();
		exc(VEC_COPROC_OVERRUN, 16'h0103, 1'b0);
		{instr_escape, mem_access, mem_len} = {2'h3, 4'h2};
		go();
		chk("exc_valid", exc_valid, 1'b0);
		{mem_access, mem_word, mem_offset} = {2'h3, 16'hffff};
		go();
		exc(VEC_SEG_OVERRUN, 16'h0100, 1'b1);
		{instr_stack, fetch_wrap} = 2'h3;
		go();
		exc(VEC_SEG_OVERRUN, 16'h0100, 1'b0);
		{mem_access, mem_word, mem_offset} = {2'h3, 16'hfffe};
		go();
		chk("exc_valid", exc_valid, 1'b0);
		end_test("addressing faults");
		instr_stop = 1'b1;
		next_ip = 16'h0101;
		go();
		chk("halted", halted, 1'b1);
		chk("bus_idle", bus_idle, 1'b1);
		chk("halt_cycle", halt_cycle, 1'b1);
		chk("halt_a1", halt_a1, 1'b1);
		maskable_request = 1'b1;
		wait_wake();
		chk("wake", got, 1'b0);
		maskable_request_enable = 1'b1;
		wait_wake();
		chk("wake", got, 1'b1);
		chk("return_ip", return_ip, 16'h0101);
		chk("halted", halted, 1'b0);
		{maskable_request, maskable_request_enable} = 2'h0;
		end_test("halt");
		vt(24'h000000, 16'h0030);
		fetch_wrap = 1'b1;
		go();
		chk("shutdown", shutdown, 1'b1);
		chk("halt_a1", halt_a1, 1'b0);
		chk("exc_valid", exc_valid, 1'b0);
		stack_pointer = 16'h0005;
		nmi_pin = 1'b1;
		wait_wake();
		chk("wake", got, 1'b0);
		nmi_pin = 1'b0;
		stack_pointer = 16'h0006;
		tick();
		nmi_pin = 1'b1;
		wait_wake();
		chk("wake", got, 1'b1);
		chk("shutdown", shutdown, 1'b0);
		chk("halt_count", halt_count, 8'h01);
		chk("shut_count", shut_count, 8'h01);
		{nmi_pin, instr_stack, instr_stack_push, stack_pointer} = {3'h3, 16'h0001};
		go();
		chk("shutdown", shutdown, 1'b1);
		end_test("shutdown");
		reset = 1'b1;
		tick();
		reset = 1'b0;
		chk("shutdown", shutdown, 1'b0);
		tick();
		ctl(16'h0001);
		chk("pe", protection_enable_bit, 1'b1);
		ctl(16'h0000);
		chk("control_word", operating_control_word, 16'hfff1);
		end_test("protect");
		report_and_stop();
	end
endmodule
